// *** rtl/bwpmc_pkg.sv ***
package bwpmc_pkg;

  // Serial command codes decoded by the link front end.
  localparam logic [7:0]  CMD_GEN_REG_READ   = 8'h65;
  localparam logic [7:0]  CMD_GEN_REG_WRITE  = 8'h71;
  localparam logic [7:0]  CMD_SET_BURST_LEN  = 8'hC0;
  localparam logic [7:0]  CMD_PROT_MODE_READ = 8'h2B;
  localparam logic [7:0]  CMD_PROT_MODE_PGM  = 8'h2F;

  // Register addresses used by the generic register commands.
  localparam logic [23:0] ADDR_BOOT_CFG      = 24'h00_0005;
  localparam logic [23:0] ADDR_LIVE_CFG      = 24'h80_0005;
  localparam logic [23:0] ADDR_PROT_LO       = 24'h00_0030;
  localparam logic [23:0] ADDR_PROT_HI       = 24'h00_0031;

  // Field positions inside the wrap and drive configuration byte.
  localparam int          DRV_MSB            = 7;
  localparam int          DRV_LSB            = 5;
  localparam int          WRAP_DIS_BIT       = 4;
  localparam int          WLEN_MSB           = 1;
  localparam int          WLEN_LSB           = 0;

  // Reset values and masks.
  localparam logic [7:0]  BOOT_CFG_RST       = 8'h10;
  localparam logic [7:0]  CFG_WRITE_MASK     = 8'hF3;
  localparam logic [15:0] PROT_RSV_ONES      = 16'hFFF9;
  localparam logic [1:0]  MODE_UNSET         = 2'b11;
  localparam logic [1:0]  MODE_PWD           = 2'b01;
  localparam logic [1:0]  MODE_PST           = 2'b10;
  localparam logic [1:0]  MODE_BOTH          = 2'b00;
  localparam logic [1:0]  MODE_KEEP          = 2'b11;

  // Frame bit counts: index of the last bit of each field, first output edge.
  localparam logic [6:0]  LAST_CMD_BIT       = 7'h07;
  localparam logic [6:0]  LAST_SBL_BIT       = 7'h0F;
  localparam logic [6:0]  LAST_PGM_BIT       = 7'h17;
  localparam logic [6:0]  LAST_ADDR_BIT      = 7'h1F;
  localparam logic [6:0]  LAST_WDATA_BIT     = 7'h27;
  localparam logic [6:0]  OUT_REG_START      = 7'h28;
  localparam logic [6:0]  OUT_PROT_START     = 7'h10;
  localparam logic [6:0]  CNT_SAT            = 7'h7F;

  // Operations handed from the link domain to the core domain.
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_RD_REG   = 3'b001,
    OP_WR_REG   = 3'b010,
    OP_SBL      = 3'b011,
    OP_PROT_RD  = 3'b100,
    OP_PROT_PGM = 3'b101
  } bwpmc_op_e;

  // Kind of array read being walked by the burst address generator.
  typedef enum logic [1:0] {
    RD_QUAD_IO     = 2'b00,
    RD_DDR_QUAD_IO = 2'b01,
    RD_OTHER_ARRAY = 2'b10,
    RD_NON_ARRAY   = 2'b11
  } bwpmc_rdkind_e;

  // One decoded request word crossing from the link to the core.
  typedef struct packed {
    bwpmc_op_e   op;
    logic [23:0] addr;
    logic [15:0] data;
  } bwpmc_req_s;

endpackage

// *** rtl/bwpmc_top.sv ***
// Behaviour
// - Reset copies boot drive and wrap fields live.
// - Live wrap bit zero selects wrapped bursts.
// - Wrap affects only quad and DDR quad reads.
// - Wrap length code sets 8/16/32/64 byte block.
// - Live drive field picks one of eight strengths.
// - Boot copy is one-time, applies after next reset.
// - Bits 3:2 reserved, boot copy holds zero.
// - Generic register read and write reach configs.
// - Set burst length command writes live config.
// - Protection register is sixteen one-time bits.
// - Dedicated read and program commands are decoded.
// - Protection bits ship as one, reserved read one.
// - Bit 2 programmed zero selects password mode.
// - Bit 1 programmed zero selects persistent mode.
// - Programming both mode bits zero flags error.
// - Programming allowed only while mode bits 11.
// - Chosen mode locks whole protection register until rst_n.
// - Other one-time bits locked once mode chosen.
// - Wrap never applies to register or OTP reads.
// - Array lock reset value follows mode bits.
`timescale 1ns/10ps
`default_nettype none

module bwpmc_top
  import bwpmc_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  // Core clock, reset and freeze.
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Hardware or software reset request from the reset controller.
  input  wire logic              warm_reset,
  // Serial link from the host.
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_si,
  output logic                   spi_so,
  output logic                   spi_so_oe,
  // Status register one, program error bit.
  input  wire logic              perr_clear,
  output logic                   prog_err,
  // Live configuration seen by the rest of the device.
  output logic [2:0]             live_drive_strength,
  output logic                   wrap_enabled,
  output logic [1:0]             live_wrap_length,
  // Protection mode state.
  output logic                   password_mode,
  output logic                   persistent_mode,
  output logic                   protection_array_lock_init,
  // Burst address generator for the read datapath.
  input  wire logic              burst_start,
  input  wire bwpmc_rdkind_e     burst_kind,
  input  wire logic [ADDR_W-1:0] burst_start_addr,
  input  wire logic              burst_step,
  output logic [ADDR_W-1:0]      burst_addr
);

  // ---------------------------------------------------------------
  // Link domain: runs on the host clock only while a frame is open.
  // ---------------------------------------------------------------

  logic [6:0]  cnt_q;      // Rising edges seen in this frame, saturating.
  logic [31:0] sh_q;       // Input shift register.
  logic [31:0] sh_d;       // Shift register including the current bit.
  logic [7:0]  cmd_q;      // Command byte of this frame.
  logic [23:0] addr_q;     // Register address of a generic access.
  bwpmc_req_s  req_q;      // Request word held stable for the core.
  bwpmc_req_s  req_d;      // Request word being issued this edge.
  logic        req_issue;  // A complete request is seen on this edge.
  logic        req_tgl_q;  // Toggles once per issued request.
  logic [15:0] so_sh_q;    // Output shift register.
  logic        so_oe_q;    // Output driver enable.
  logic [6:0]  out_start;  // Edge count at which read data starts.
  logic [15:0] rd_word_q;  // Read answer held by the core domain.

  assign sh_d = {sh_q[30:0], spi_si};

  // Bit counter; chip select high clears it without needing a clock edge.
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      cnt_q <= 7'h00;
    end else if (cnt_q != CNT_SAT) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // Input shifter and the command and address captures.
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      sh_q   <= 32'h0000_0000;
      cmd_q  <= 8'h00;
      addr_q <= 24'h00_0000;
    end else begin
      sh_q <= sh_d;
      if (cnt_q == LAST_CMD_BIT) begin
        cmd_q <= sh_d[7:0];
      end
      if (cnt_q == LAST_ADDR_BIT) begin
        addr_q <= sh_d[23:0];
      end
    end
  end

  // Command decode: decides on which edge each command is complete.
  always_comb begin
    req_issue = 1'b0;
    req_d     = req_q;
    if (cnt_q == LAST_CMD_BIT && sh_d[7:0] == CMD_PROT_MODE_READ) begin
      // The read answer is fetched early so it is ready after the dummy byte.
      req_issue = 1'b1;
      req_d.op  = OP_PROT_RD;
    end else begin
      case (cmd_q)
        CMD_GEN_REG_READ: begin
          if (cnt_q == LAST_ADDR_BIT) begin
            req_issue  = 1'b1;
            req_d.op   = OP_RD_REG;
            req_d.addr = sh_d[23:0];
          end
        end
        CMD_GEN_REG_WRITE: begin
          if (cnt_q == LAST_WDATA_BIT) begin
            req_issue  = 1'b1;
            req_d.op   = OP_WR_REG;
            req_d.addr = addr_q;
            req_d.data = {8'h00, sh_d[7:0]};
          end
        end
        CMD_SET_BURST_LEN: begin
          if (cnt_q == LAST_SBL_BIT) begin
            req_issue  = 1'b1;
            req_d.op   = OP_SBL;
            req_d.data = {8'h00, sh_d[7:0]};
          end
        end
        CMD_PROT_MODE_PGM: begin
          if (cnt_q == LAST_PGM_BIT) begin
            // Low byte travels first on the wire.
            req_issue  = 1'b1;
            req_d.op   = OP_PROT_PGM;
            req_d.data = {sh_d[7:0], sh_d[15:8]};
          end
        end
        default: begin
          // Unknown commands are ignored by this block.
          req_issue = 1'b0;
        end
      endcase
    end
  end

  // Request hand-off; not cleared by chip select so no toggle is lost.
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      req_q     <= '{op: OP_NONE, addr: 24'h00_0000, data: 16'h0000};
      req_tgl_q <= 1'b0;
    end else if (req_issue) begin
      req_q     <= req_d;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // Read data starts after the dummy byte that follows the request.
  always_comb begin
    case (cmd_q)
      CMD_GEN_REG_READ:   out_start = OUT_REG_START;
      CMD_PROT_MODE_READ: out_start = OUT_PROT_START;
      default:            out_start = CNT_SAT;
    endcase
  end

  // Output shifter on the falling edge so the host samples on the rising one.
  // The dummy byte gives the core several clocks to post rd_word_q, which
  // then stays still while it is sampled here.
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      so_sh_q <= 16'h0000;
      so_oe_q <= 1'b0;
    end else if (cnt_q == out_start && out_start != CNT_SAT) begin
      so_sh_q <= rd_word_q;
      so_oe_q <= 1'b1;
    end else begin
      so_sh_q <= {so_sh_q[14:0], 1'b0};
    end
  end

  assign spi_so    = so_sh_q[15];
  assign spi_so_oe = so_oe_q;

  // ---------------------------------------------------------------
  // Core domain.
  // ---------------------------------------------------------------

  logic [2:0]  tgl_sync_q;  // Two synchroniser stages and an edge stage.
  logic        exec;        // One core cycle per received request.
  logic [7:0]  boot_q;      // boot_wrap_drive_config, one-time storage.
  logic [7:0]  live_q;      // live_wrap_drive_config.
  logic [1:0]  mode_q;      // Password and persistent mode lock bits.
  logic        perr_q;      // Program error, bit 6 of status one.
  logic [15:0] prot_word;   // protection_mode_lock as read.
  logic [15:0] rd_word_d;   // Next read answer.
  logic        boot_wr;     // Program attempt on the boot copy.
  logic        live_wr;     // Write of the live copy.
  logic        prot_pgm;    // Program attempt on the protection register.
  logic [1:0]  pgm_bits;    // Mode bits carried by that attempt.
  logic        unlocked;    // No protection mode chosen yet.
  logic        prot_err;    // Rejected protection program.

  // Toggle synchroniser; the second stage and the edge stage feed the edge compare, the first never does.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgl_sync_q <= 3'b000;
    end else if (clk_en) begin
      tgl_sync_q <= {tgl_sync_q[1:0], req_tgl_q};
    end
  end

  assign exec     = clk_en && (tgl_sync_q[2] != tgl_sync_q[1]);
  assign unlocked = (mode_q == MODE_UNSET);

  // Access decode of the stable request word.
  always_comb begin
    boot_wr  = exec && req_q.op == OP_WR_REG && req_q.addr == ADDR_BOOT_CFG;
    live_wr  = exec && ((req_q.op == OP_WR_REG && req_q.addr == ADDR_LIVE_CFG)
                        || req_q.op == OP_SBL);
    prot_pgm = exec && (req_q.op == OP_PROT_PGM
                        || (req_q.op == OP_WR_REG
                            && (req_q.addr == ADDR_PROT_LO || req_q.addr == ADDR_PROT_HI)));
    if (req_q.op == OP_PROT_PGM || req_q.addr == ADDR_PROT_LO) begin
      pgm_bits = req_q.data[2:1];
    end else begin
      // The high byte holds only reserved bits, so mode bits stay as they are.
      pgm_bits = MODE_KEEP;
    end
    // Any program with a mode chosen, or one choosing both modes, fails.
    prot_err = prot_pgm && (!unlocked || pgm_bits == MODE_BOTH);
  end

  // Boot copy: programmable only before a protection mode is chosen, and
  // never reset by warm reset, since it models one-time storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_q <= BOOT_CFG_RST;
    end else if (boot_wr && unlocked) begin
      boot_q <= req_q.data[7:0] & CFG_WRITE_MASK;
    end
  end

  // Live copy: reloaded from the boot copy at each warm reset seen while clk_en is high, written by the
  // generic write and by set burst length in between.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live_q <= BOOT_CFG_RST;
    end else if (clk_en && warm_reset) begin
      live_q <= boot_q;
    end else if (live_wr) begin
      live_q <= req_q.data[7:0] & CFG_WRITE_MASK;
    end
  end

  // Protection mode bits: can only go from one to zero, and only once.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= MODE_UNSET;
    end else if (prot_pgm && !prot_err) begin
      mode_q <= mode_q & pgm_bits;
    end
  end

  // Sticky program error; a new error wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perr_q <= 1'b0;
    end else if (clk_en) begin
      if (prot_err || (boot_wr && !unlocked)) begin
        perr_q <= 1'b1;
      end else if (perr_clear) begin
        perr_q <= 1'b0;
      end
    end
  end

  // The full sixteen-bit view; every reserved bit reads as one.
  assign prot_word = PROT_RSV_ONES | {13'h0000, mode_q, 1'b0};

  // Read answer selection; unmapped addresses answer zero.
  always_comb begin
    rd_word_d = rd_word_q;
    case (req_q.op)
      OP_RD_REG: begin
        case (req_q.addr)
          ADDR_BOOT_CFG: rd_word_d = {boot_q, 8'h00};
          ADDR_LIVE_CFG: rd_word_d = {live_q, 8'h00};
          ADDR_PROT_LO:  rd_word_d = {prot_word[7:0], 8'h00};
          ADDR_PROT_HI:  rd_word_d = {prot_word[15:8], 8'h00};
          default:       rd_word_d = 16'h0000;
        endcase
      end
      OP_PROT_RD: rd_word_d = {prot_word[7:0], prot_word[15:8]};
      default:    rd_word_d = rd_word_q;
    endcase
  end

  // Read answer register, updated only when a request arrives.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_word_q <= 16'h0000;
    end else if (exec) begin
      rd_word_q <= rd_word_d;
    end
  end

  // Configuration and mode outputs.
  assign live_drive_strength        = live_q[DRV_MSB:DRV_LSB];
  assign wrap_enabled               = !live_q[WRAP_DIS_BIT];
  assign live_wrap_length           = live_q[WLEN_MSB:WLEN_LSB];
  assign password_mode              = (mode_q == MODE_PWD);
  assign persistent_mode            = (mode_q == MODE_PST);
  assign protection_array_lock_init = (mode_q != MODE_PWD);
  assign prog_err                   = perr_q;

  // ---------------------------------------------------------------
  // Burst address generator. Length is read live, so a change of the
  // live copy applies to the very next step of a burst in flight.
  // ---------------------------------------------------------------

  bwpmc_rdkind_e     kind_q;       // Kind of the burst in progress.
  logic [ADDR_W-1:0] burst_addr_q; // Current byte address.
  logic [ADDR_W-1:0] addr_inc;     // Linear next address.
  logic [5:0]        wmask;        // Offset bits that wrap.
  logic              wrap_active;  // This burst wraps.

  always_comb begin
    case (live_q[WLEN_MSB:WLEN_LSB])
      2'b00:   wmask = 6'h07;
      2'b01:   wmask = 6'h0F;
      2'b10:   wmask = 6'h1F;
      default: wmask = 6'h3F;
    endcase
  end

  // Register and OTP reads never wrap, nor do other array read commands.
  assign wrap_active = !live_q[WRAP_DIS_BIT]
                       && (kind_q == RD_QUAD_IO || kind_q == RD_DDR_QUAD_IO);
  assign addr_inc    = burst_addr_q + ADDR_W'(1);

  // Step inside the aligned block, or linearly.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burst_addr_q <= '0;
      kind_q       <= RD_OTHER_ARRAY;
    end else if (clk_en) begin
      if (burst_start) begin
        burst_addr_q <= burst_start_addr;
        kind_q       <= burst_kind;
      end else if (burst_step && wrap_active) begin
        burst_addr_q <= {burst_addr_q[ADDR_W-1:6],
                         (burst_addr_q[5:0] & ~wmask) | (addr_inc[5:0] & wmask)};
      end else if (burst_step) begin
        burst_addr_q <= addr_inc;
      end
    end
  end

  assign burst_addr = burst_addr_q;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------

  a_live_reload: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && warm_reset) |=> (live_q == $past(boot_q)))
    else $error("live config not reloaded from boot copy");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_q[3:2] == 2'b00) && (live_q[3:2] == 2'b00))
    else $error("reserved config bits not zero");

  a_wrap_in_block: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && burst_step && !burst_start && wrap_active)
    |=> (((burst_addr_q ^ $past(burst_addr_q)) & {{(ADDR_W-6){1'b1}}, ~$past(wmask)}) == '0))
    else $error("wrapped step left its aligned block");

  a_wrap_returns: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && burst_step && !burst_start && wrap_active && ((burst_addr_q[5:0] & wmask) == wmask))
    |=> ((burst_addr_q[5:0] & $past(wmask)) == 6'h00))
    else $error("wrapped burst did not return to block start");

  a_linear_other: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && burst_step && !burst_start
     && (live_q[WRAP_DIS_BIT] || kind_q == RD_OTHER_ARRAY || kind_q == RD_NON_ARRAY))
    |=> (burst_addr_q == $past(addr_inc)))
    else $error("non-wrapping read did not step linearly");

  a_prot_locked: assert property (@(posedge clk) disable iff (!rst_n)
    (prot_pgm && mode_q != MODE_UNSET) |=> (mode_q == $past(mode_q)) && perr_q)
    else $error("locked protection register changed or no error");

  a_prot_both_err: assert property (@(posedge clk) disable iff (!rst_n)
    (prot_pgm && unlocked && pgm_bits == MODE_BOTH) |=> perr_q && (mode_q == MODE_UNSET))
    else $error("both mode bits programmed without error");

  a_boot_locked: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_wr && !unlocked) |=> (boot_q == $past(boot_q)) && perr_q)
    else $error("boot copy programmed after mode choice");

  a_boot_deferred: assert property (@(posedge clk) disable iff (!rst_n)
    (boot_wr && unlocked && !live_wr && !warm_reset) |=> (live_q == $past(live_q)))
    else $error("boot program changed live copy before reset");

  a_sbl_write: assert property (@(posedge clk) disable iff (!rst_n)
    (exec && req_q.op == OP_SBL && !warm_reset)
    |=> (live_q == ($past(req_q.data[7:0]) & CFG_WRITE_MASK)))
    else $error("set burst length did not write live copy");

  a_perr_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (perr_q && !(clk_en && perr_clear)) |=> perr_q)
    else $error("program error dropped without clear");

  a_prot_read: assert property (@(posedge clk) disable iff (!rst_n)
    (exec && req_q.op == OP_PROT_RD)
    |=> (rd_word_q[7:0] == 8'hFF) && (rd_word_q[15:11] == 5'h1F) && rd_word_q[8])
    else $error("protection read reserved bits not one");

endmodule

`default_nettype wire

// *** verification/bwpmc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host controller model: mode 0 frames, and the link clock stands still between frames.
module bwpmc_host (
  // Serial link.
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so
);
  // The link idles deselected with its clock low.
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end
  // Sends ntx bits MSB first, then captures nrx bits on rising edges.
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, output logic [15:0] rx);
    rx = 16'h0000;
    #13 spi_cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      spi_si = (i < ntx) ? tx[63-i] : ~spi_si;
      #32 spi_sck = 1'b1;
      if (i >= ntx) begin
        rx = {rx[14:0], spi_so};
      end
      #32 spi_sck = 1'b0;
    end
    spi_cs_n = 1'b1;
    // A toggled data line keeps a stale bit from passing for a real one.
    spi_si = ~spi_si;
    // The gap lets the core finish the request before the next frame.
    #1000;
  endtask
endmodule
`default_nettype wire

// *** verification/bwpmc_top_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module bwpmc_top_test;
  import bwpmc_pkg::*;
  logic clk, clk_en, rst_n, warm_reset, perr_clear, burst_start, burst_step;
  logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, prog_err, wrap_enabled;
  logic password_mode, persistent_mode, protection_array_lock_init;
  logic [2:0] live_drive_strength;
  logic [1:0] live_wrap_length;
  logic [23:0] burst_start_addr, burst_addr;
  bwpmc_rdkind_e burst_kind;
  int n_errors, num_checks;
  // Link edges seen with the device driving its output; the reads check how many.
  int oe_edges = 0;
  // Core clock at 10 MHz.
  always #50 clk = ~clk;
  bwpmc_top uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .warm_reset(warm_reset),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .perr_clear(perr_clear), .prog_err(prog_err), .live_drive_strength(live_drive_strength),
    .wrap_enabled(wrap_enabled), .live_wrap_length(live_wrap_length), .password_mode(password_mode),
    .persistent_mode(persistent_mode), .protection_array_lock_init(protection_array_lock_init),
    .burst_start(burst_start), .burst_kind(burst_kind), .burst_start_addr(burst_start_addr),
    .burst_step(burst_step), .burst_addr(burst_addr));
  bwpmc_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));
  // The host samples on rising link edges, so the enable is counted there too.
  always @(posedge spi_sck) begin
    if (spi_so_oe) begin
      oe_edges++;
    end
  end
  // Compares a port value.
  task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compares a register read back over the link.
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A register read drives the output for exactly one byte and then lets go.
  task automatic rd_chk(input logic [23:0] a, input logic [15:0] e);
    logic [15:0] d;
    int          n0;
    n0 = oe_edges;
    host.frame({CMD_GEN_REG_READ, a, 32'h0000_0000}, 40, 8, d);
    chk_reg(d, e);
    chk_pin(24'(oe_edges - n0), 24'h00_0008);
    chk_pin({23'h00_0000, spi_so_oe}, 24'h00_0000);
  endtask
  task automatic wr_cfg(input logic [23:0] a, input logic [7:0] v);
    logic [15:0] r;
    host.frame({CMD_GEN_REG_WRITE, a, v, 24'h00_0000}, 40, 0, r);
  endtask
  task automatic set_burst_length_cmd(input logic [7:0] v);
    logic [15:0] r;
    host.frame({CMD_SET_BURST_LEN, v, 48'h0000_0000_0000}, 16, 0, r);
  endtask
  // Low byte travels first on both protection commands.
  task automatic prot_chk(input logic [15:0] e);
    logic [15:0] r;
    int          n0;
    n0 = oe_edges;
    host.frame({CMD_PROT_MODE_READ, 56'h0}, 16, 16, r);
    chk_reg({r[7:0], r[15:8]}, e);
    chk_pin(24'(oe_edges - n0), 24'h00_0010);
  endtask
  task automatic pgm_prot(input logic [15:0] v);
    logic [15:0] r;
    host.frame({CMD_PROT_MODE_PGM, v[7:0], v[15:8], 40'h00_0000_0000}, 24, 0, r);
  endtask
  // Live byte as seen at the outputs, reserved bits shown as zero.
  task automatic cfg_chk(input logic [7:0] v);
    chk_pin({16'h0000, live_drive_strength, ~wrap_enabled, 2'b00, live_wrap_length}, {16'h0000, v});
  endtask
  // Error flag, password, persistent and array lock reset value.
  task automatic mode_chk(input logic [3:0] e);
    chk_pin({20'h0_0000, prog_err, password_mode, persistent_mode, protection_array_lock_init}, {20'h0_0000, e});
  endtask
  // One-cycle core pulse: warm reset when w is set, else error clear.
  task automatic strobe(input logic w);
    @(posedge clk);
    warm_reset <= w;
    perr_clear <= ~w;
    @(posedge clk);
    warm_reset <= 1'b0;
    perr_clear <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic bstart(input bwpmc_rdkind_e k, input logic [23:0] a);
    @(posedge clk);
    burst_start <= 1'b1;
    burst_kind <= k;
    burst_start_addr <= a;
    @(posedge clk);
    burst_start <= 1'b0;
  endtask
  task automatic bstep(input logic [23:0] e);
    @(posedge clk);
    burst_step <= 1'b1;
    @(posedge clk);
    burst_step <= 1'b0;
    #1 chk_pin(burst_addr, e);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A frame takes about 4 us, so 2 ms is far beyond the whole sequence.
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
  initial begin
    {clk, warm_reset, perr_clear, burst_start, burst_step} = 5'h00;
    clk_en = 1'b1;
    burst_kind = RD_QUAD_IO;
    burst_start_addr = 24'h00_0000;
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    do_reset();
    cfg_chk(BOOT_CFG_RST);
    mode_chk(4'h1);
    rd_chk(ADDR_BOOT_CFG, 16'h0010);
    rd_chk(24'h00_0123, 16'h0000);
    prot_chk(16'hFFFF);
    wr_cfg(ADDR_LIVE_CFG, 8'hEF);
    cfg_chk(8'hE3);
    rd_chk(ADDR_LIVE_CFG, 16'h00E3);
    set_burst_length_cmd(8'h52);
    cfg_chk(8'h52);
    // The host settles the one-time bits before any mode is chosen
    wr_cfg(ADDR_BOOT_CFG, 8'hA1);
    cfg_chk(8'h52);
    // A reset pulse while the core is frozen must not reload the live copy.
    @(posedge clk);
    clk_en <= 1'b0;
    strobe(1'b1);
    cfg_chk(8'h52);
    @(posedge clk);
    clk_en <= 1'b1;
    strobe(1'b1);
    cfg_chk(8'hA1);
    for (int l = 0; l < 4; l++) begin
      set_burst_length_cmd({6'h00, l[1:0]});
      bstart(RD_QUAD_IO, 24'h00_00FF + (24'h00_0008 << l));
      bstep(24'h00_0100);
      bstep(24'h00_0101);
    end
    for (int k = 0; k < 4; k++) begin
      bstart(bwpmc_rdkind_e'(k[1:0]), 24'h00_013F);
      bstep((k < 2) ? 24'h00_0100 : 24'h00_0140);
    end
    set_burst_length_cmd(8'h13);
    bstart(RD_QUAD_IO, 24'h00_013F);
    bstep(24'h00_0140);
    pgm_prot(16'hFFF9);
    mode_chk(4'h9);
    prot_chk(16'hFFFF);
    strobe(1'b0);
    pgm_prot(16'hFFFD);
    mode_chk(4'h3);
    prot_chk(16'hFFFD);
    pgm_prot(16'hFFFB);
    mode_chk(4'hB);
    prot_chk(16'hFFFD);
    strobe(1'b0);
    wr_cfg(ADDR_BOOT_CFG, 8'h00);
    mode_chk(4'hB);
    rd_chk(ADDR_BOOT_CFG, 16'h00A1);
    rd_chk(ADDR_PROT_LO, 16'h00FD);
    rd_chk(ADDR_PROT_HI, 16'h00FF);
    // The generic write path into the protection register is locked as well.
    strobe(1'b0);
    wr_cfg(ADDR_PROT_LO, 8'hFB);
    mode_chk(4'hB);
    prot_chk(16'hFFFD);
    do_reset();
    pgm_prot(16'hFFFB);
    mode_chk(4'h4);
    close_out();
  end
endmodule
`default_nettype wire
